// file: rtl/tobs_defs.svh
// Constants for the touch output and burst scheduler.
`ifndef TOBS_DEFS_SVH
`define TOBS_DEFS_SVH

// ============================================================
// Timing
`define TOBS_CLK_PERIOD_NS  5
`define TOBS_MS_NS          1000000
`define TOBS_LATCH_SHORT_MS 15'h0bb8
`define TOBS_LATCH_LONG_MS  15'h7530
`define TOBS_SP_SLOW_MS     5'h14
`define TOBS_SP_FAST_MS     5'h0a
`define TOBS_GAP_LP         5'h04
`define TOBS_GAP_XLP        5'h10

// ============================================================
// Register offsets
`define TOBS_ADDR_CFG0      2'h0
`define TOBS_ADDR_CFG1      2'h1
`define TOBS_ADDR_CTRL      2'h2
`define TOBS_ADDR_STATUS    2'h3

// ============================================================
// Field positions and reset values
`define TOBS_OM_LSB         0
`define TOBS_THR_LSB        4
`define TOBS_PM_LSB         6
`define TOBS_FREQ_BIT       1
`define TOBS_SP_BIT         2
`define TOBS_LOCK_BIT       0
`define TOBS_CFG_RESET      8'h00

`endif

// file: rtl/tobs_pkg.sv
// Types for the touch output and burst scheduler.
package tobs_pkg;

   // ============================================================
   // Output and power modes, in field encoding order
   typedef enum logic [1:0] {
      TOBS_OM_ACTIVE,
      TOBS_OM_TOGGLE,
      TOBS_OM_LATCH_SHORT,
      TOBS_OM_LATCH_LONG
   } tobs_out_mode_t;

   typedef enum logic [1:0] {
      TOBS_PM_LOW_ZOOM,
      TOBS_PM_NORMAL,
      TOBS_PM_XLOW_ZOOM,
      TOBS_PM_XLOW
   } tobs_power_mode_t;

endpackage

// file: rtl/tobs_top.sv
// Detection output shaping and acquisition burst scheduling.
//
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/100ps
`include "tobs_defs.svh"

module tobs_top
   import tobs_pkg::*;
#(
   parameter int MS_CYCLES   = `TOBS_MS_NS / `TOBS_CLK_PERIOD_NS,
   parameter int MIN_HIGH_MS = 20,
   parameter int ELP_PERIODS = 50
) (
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic [1:0] addr,
   input  wire logic [7:0] wr_data,
   input  wire logic       wr_en,
   input  wire logic       rd_en,
   output logic      [7:0] rd_data,
   input  wire logic       detect_in,
   output logic            detect_output,
   output logic            burst_start,
   output logic            transfer_fast,
   output logic      [1:0] detect_threshold,
   output logic            sample_fast
);

   // ============================================================
   // Reset synchroniser
   logic rst_meta_q;
   logic rst_n_q;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_meta_q <= 1'b0;
         rst_n_q    <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q    <= rst_meta_q;
      end
   end

   // ============================================================
   // Configuration registers
   // Config stays writable only until the lock bit is set, which models the
   // one-time load of the option bytes; afterwards the settings never move.
   logic [7:0]       cfg0_q;
   logic [7:0]       cfg1_q;
   logic             lock_q;
   tobs_out_mode_t   out_mode;
   tobs_power_mode_t pwr_mode;

   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         cfg0_q <= `TOBS_CFG_RESET;
         cfg1_q <= `TOBS_CFG_RESET;
         lock_q <= 1'b0;
      end else if (wr_en && !lock_q) begin
         if (addr == `TOBS_ADDR_CFG0) begin
            cfg0_q <= wr_data;
         end
         if (addr == `TOBS_ADDR_CFG1) begin
            cfg1_q <= wr_data;
         end
         if (addr == `TOBS_ADDR_CTRL) begin
            lock_q <= wr_data[`TOBS_LOCK_BIT];
         end
      end
   end

   assign out_mode = tobs_out_mode_t'(cfg0_q[`TOBS_OM_LSB +: 2]);
   assign pwr_mode = tobs_power_mode_t'(cfg0_q[`TOBS_PM_LSB +: 2]);

   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         transfer_fast    <= 1'b0;
         detect_threshold <= 2'h0;
         sample_fast      <= 1'b0;
      end else begin
         transfer_fast    <= cfg1_q[`TOBS_FREQ_BIT];
         detect_threshold <= cfg0_q[`TOBS_THR_LSB +: 2];
         sample_fast      <= cfg1_q[`TOBS_SP_BIT];
      end
   end

   // ============================================================
   // Millisecond tick
   logic [31:0] ms_cnt_q;
   logic        ms_tick_q;

   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ms_cnt_q  <= 32'h0;
         ms_tick_q <= 1'b0;
      end else if (ms_cnt_q == 32'(MS_CYCLES - 1)) begin
         ms_cnt_q  <= 32'h0;
         ms_tick_q <= lock_q;
      end else begin
         ms_cnt_q  <= ms_cnt_q + 32'h1;
         ms_tick_q <= 1'b0;
      end
   end

   // ============================================================
   // Detection edge
   logic det_prev_q;
   logic det_rise;
   logic det_fall;

   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         det_prev_q <= 1'b0;
      end else begin
         det_prev_q <= detect_in && lock_q;
      end
   end

   assign det_rise = detect_in && lock_q && !det_prev_q;
   assign det_fall = !(detect_in && lock_q) && det_prev_q;

   // ============================================================
   // Output shaping
   logic        tgl_q;
   logic [14:0] lat_q;
   logic [15:0] hold_q;
   logic        want;
   logic        out_d;

   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         tgl_q <= 1'b0;
      end else if (out_mode != TOBS_OM_TOGGLE) begin
         tgl_q <= 1'b0;
      end else if (det_rise) begin
         tgl_q <= !tgl_q;
      end
   end

   // The latch timer counts whole milliseconds, so a hold may run up to one
   // tick short of the nominal time; well inside any human-visible margin.
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         lat_q <= 15'h0;
      end else if (out_mode == TOBS_OM_LATCH_SHORT && det_rise) begin
         lat_q <= `TOBS_LATCH_SHORT_MS;
      end else if (out_mode == TOBS_OM_LATCH_LONG && det_fall) begin
         lat_q <= `TOBS_LATCH_LONG_MS;
      end else if (out_mode == TOBS_OM_LATCH_LONG && detect_in) begin
         lat_q <= 15'h0;
      end else if (ms_tick_q && lat_q != 15'h0) begin
         lat_q <= lat_q - 15'h1;
      end
   end

   always_comb begin
      unique case (out_mode)
         TOBS_OM_ACTIVE:      want = detect_in && lock_q;
         TOBS_OM_TOGGLE:      want = tgl_q;
         TOBS_OM_LATCH_SHORT: want = (detect_in && lock_q) || lat_q != 15'h0;
         // The delayed detection bridges the cycle before the hold counter loads.
         TOBS_OM_LATCH_LONG:  want = (detect_in && lock_q) || det_prev_q || lat_q != 15'h0;
      endcase
   end

   // A fall is deferred, never dropped, while the minimum high time runs.
   assign out_d = want || (detect_output && hold_q != 16'h0);

   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         hold_q <= 16'h0;
      end else if (out_d && !detect_output) begin
         hold_q <= 16'(MIN_HIGH_MS);
      end else if (ms_tick_q && hold_q != 16'h0) begin
         hold_q <= hold_q - 16'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         detect_output <= 1'b0;
      end else begin
         detect_output <= out_d;
      end
   end

   // ============================================================
   // Burst scheduler
   logic [4:0] sp_ms_q;
   logic [4:0] sp_len;
   logic       sp_tick;
   logic [4:0] skip_q;
   logic [4:0] gap;
   logic       woke_q;
   logic [7:0] quiet_q;
   logic       zoom;

   assign sp_len  = cfg1_q[`TOBS_SP_BIT] ? `TOBS_SP_FAST_MS : `TOBS_SP_SLOW_MS;
   assign sp_tick = ms_tick_q && sp_ms_q == sp_len - 5'h1;
   assign zoom    = pwr_mode == TOBS_PM_LOW_ZOOM || pwr_mode == TOBS_PM_XLOW_ZOOM;

   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         sp_ms_q <= 5'h0;
      end else if (sp_tick) begin
         sp_ms_q <= 5'h0;
      end else if (ms_tick_q) begin
         sp_ms_q <= sp_ms_q + 5'h1;
      end
   end

   // Wake on detection; the set wins over the quiet-timeout clear.
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         woke_q  <= 1'b0;
         quiet_q <= 8'h0;
      end else if (!zoom) begin
         woke_q  <= 1'b0;
         quiet_q <= 8'h0;
      end else if (detect_in && lock_q) begin
         woke_q  <= 1'b1;
         quiet_q <= 8'h0;
      end else if (sp_tick && woke_q) begin
         if (quiet_q == 8'(ELP_PERIODS - 1)) begin
            woke_q  <= 1'b0;
            quiet_q <= 8'h0;
         end else begin
            quiet_q <= quiet_q + 8'h1;
         end
      end
   end

   always_comb begin
      unique case (pwr_mode)
         TOBS_PM_NORMAL:    gap = 5'h0;
         TOBS_PM_LOW_ZOOM:  gap = woke_q ? 5'h0 : `TOBS_GAP_LP;
         TOBS_PM_XLOW_ZOOM: gap = woke_q ? 5'h0 : `TOBS_GAP_XLP;
         TOBS_PM_XLOW:      gap = `TOBS_GAP_XLP;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         skip_q      <= 5'h0;
         burst_start <= 1'b0;
      end else begin
         burst_start <= 1'b0;
         if (woke_q && zoom) begin
            skip_q <= 5'h0;
            if (sp_tick) begin
               burst_start <= 1'b1;
            end
         end else if (sp_tick) begin
            if (skip_q == 5'h0) begin
               burst_start <= 1'b1;
               skip_q      <= gap;
            end else begin
               skip_q <= skip_q - 5'h1;
            end
         end
      end
   end

   // ============================================================
   // Register read
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         rd_data <= 8'h00;
      end else if (rd_en) begin
         unique case (addr)
            `TOBS_ADDR_CFG0:   rd_data <= cfg0_q;
            `TOBS_ADDR_CFG1:   rd_data <= cfg1_q;
            `TOBS_ADDR_CTRL:   rd_data <= {7'h00, lock_q};
            `TOBS_ADDR_STATUS: rd_data <= {4'h0, woke_q, tgl_q, detect_output, det_prev_q};
         endcase
      end else begin
         rd_data <= 8'h00;
      end
   end

   // ============================================================
   // Assertions
   // One actuation while the short latch is selected.
   sequence s_short_touch;
      out_mode == TOBS_OM_LATCH_SHORT && det_rise;
   endsequence

   // The long latch output stays up across the cycle in which its counter loads.
   sequence s_long_hold;
      detect_output ##1 lat_q == `TOBS_LATCH_LONG_MS && detect_output ##1 detect_output;
   endsequence

   a_active_follow: assert property (@(posedge clk) disable iff (!rst_n_q)
      out_mode == TOBS_OM_ACTIVE && det_rise |=> detect_output)
      else $error("Active mode output did not rise.");

   a_toggle_flip: assert property (@(posedge clk) disable iff (!rst_n_q)
      out_mode == TOBS_OM_TOGGLE && det_rise |=> tgl_q != $past(tgl_q))
      else $error("Toggle state did not invert.");

   a_min_high: assert property (@(posedge clk) disable iff (!rst_n_q)
      $fell(detect_output) |-> $past(hold_q) == 16'h0)
      else $error("Output fell before minimum high time.");

   a_short_latch: assert property (@(posedge clk) disable iff (!rst_n_q)
      s_short_touch |=> lat_q == `TOBS_LATCH_SHORT_MS && detect_output)
      else $error("Short latch not loaded with three seconds.");

   a_short_stay: assert property (@(posedge clk) disable iff (!rst_n_q)
      out_mode == TOBS_OM_LATCH_SHORT && detect_output && detect_in ##1 detect_in
      |-> detect_output)
      else $error("Short latch output dropped during detection.");

   a_long_restart: assert property (@(posedge clk) disable iff (!rst_n_q)
      out_mode == TOBS_OM_LATCH_LONG && det_fall |-> s_long_hold)
      else $error("Long latch hold not restarted.");

   a_normal_burst: assert property (@(posedge clk) disable iff (!rst_n_q)
      pwr_mode == TOBS_PM_NORMAL && sp_tick |=> burst_start)
      else $error("Normal mode missed a burst.");

   a_xlp_gap: assert property (@(posedge clk) disable iff (!rst_n_q)
      pwr_mode == TOBS_PM_XLOW && burst_start |-> skip_q == `TOBS_GAP_XLP)
      else $error("Extreme low power gap not sixteen periods.");

   a_zoom_wake: assert property (@(posedge clk) disable iff (!rst_n_q)
      zoom && detect_in && lock_q |=> woke_q)
      else $error("Zoom mode did not wake on detection.");

   a_cfg_static: assert property (@(posedge clk) disable iff (!rst_n_q)
      lock_q |=> $stable(cfg0_q) && $stable(cfg1_q) && lock_q)
      else $error("Configuration changed after lock.");

   // The burst just after a return to reduced rate is excluded, as it starts from zero skip.
   a_lp_zoom_gap: assert property (@(posedge clk) disable iff (!rst_n_q)
      pwr_mode == TOBS_PM_LOW_ZOOM && burst_start && !woke_q && !$past(woke_q)
      |-> skip_q == `TOBS_GAP_LP)
      else $error("Low power zoom gap not four periods.");

   a_xlz_gap: assert property (@(posedge clk) disable iff (!rst_n_q)
      pwr_mode == TOBS_PM_XLOW_ZOOM && burst_start && !woke_q && !$past(woke_q)
      |-> skip_q == `TOBS_GAP_XLP)
      else $error("Extreme zoom gap not sixteen periods.");

   a_zoom_return: assert property (@(posedge clk) disable iff (!rst_n_q)
      zoom && woke_q && sp_tick && !(detect_in && lock_q)
      && quiet_q == 8'(ELP_PERIODS - 1) |=> !woke_q)
      else $error("Zoom mode did not return to reduced rate.");

   a_active_drop: assert property (@(posedge clk) disable iff (!rst_n_q)
      out_mode == TOBS_OM_ACTIVE && det_fall && hold_q == 16'h0 |=> !detect_output)
      else $error("Active mode output outlived the detection.");

endmodule

// file: sim/tobs_load.sv
// Behavioural LED load that measures how long the detection output stays high.
`timescale 1ns/100ps

module tobs_load (
   input  wire logic        clk,
   input  wire logic        detect_output,
   output logic      [31:0] high_len
);
   logic [31:0] cnt_q;

   initial begin
      cnt_q = 32'h0;
      high_len = 32'h0;
   end

   // ============================================================
   // Pulse width meter
   // The width is published one edge after the fall, so readers wait one extra cycle.
   always @(posedge clk) begin
      if (detect_output === 1'b1) begin
         cnt_q <= cnt_q + 32'h1;
      end else if (cnt_q != 32'h0) begin
         high_len <= cnt_q;
         cnt_q <= 32'h0;
      end
   end
endmodule

// file: sim/tobs_top_tb.sv
// Self-checking testbench for the detection output and burst scheduler.
`timescale 1ns/100ps

module tobs_top_tb;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic [1:0]  addr = 2'h0;
   logic [7:0]  wr_data = 8'h00;
   logic        wr_en = 1'b0;
   logic        rd_en = 1'b0;
   logic        detect_in = 1'b0;
   logic [7:0]  rd_data;
   logic        detect_output;
   logic        burst_start;
   logic        transfer_fast;
   logic [1:0]  detect_threshold;
   logic        sample_fast;
   logic [31:0] high_len;
   int          mismatches = 0;
   int          comparisons = 0;
   int          cyc = 0;

   always #2.5 clk = ~clk;

   // One ms is one cycle here so the thirty second latch fits in the run.
   tobs_top #(.MS_CYCLES(1), .MIN_HIGH_MS(4), .ELP_PERIODS(3)) DUT (
      .clk(clk), .resetn(resetn), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
      .rd_en(rd_en), .rd_data(rd_data), .detect_in(detect_in),
      .detect_output(detect_output), .burst_start(burst_start),
      .transfer_fast(transfer_fast), .detect_threshold(detect_threshold),
      .sample_fast(sample_fast));

   tobs_load u_load (.clk(clk), .detect_output(detect_output), .high_len(high_len));

   // ============================================================
   // Compare and report
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
      comparisons++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h to %h", $time, got, lo, hi);
      end
   endtask

   task automatic print_verdict;
      $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         mismatches++;
         print_verdict;
      end
   end

   // ============================================================
   // Bus and stimulus tasks, entered and left just after a rising edge
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd(input logic [1:0] a, input logic [7:0] exp);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 chk(rd_data, exp);
      @(posedge clk);
   endtask

   // Configuration is only taken before lock, so every test starts from reset.
   task automatic restart(input logic [7:0] c0, input logic [7:0] c1);
      resetn <= 1'b0;
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      wr(2'h0, c0);
      wr(2'h1, c1);
      wr(2'h2, 8'h01);
   endtask

   task automatic det(input int n);
      detect_in <= 1'b1;
      repeat (n) @(posedge clk);
      detect_in <= 1'b0;
      @(posedge clk);
   endtask

   task automatic gap(input logic [31:0] exp);
      logic [31:0] n;
      n = 32'h0;
      #1;
      while (burst_start !== 1'b1 && n < 32'd3000) begin
         @(posedge clk);
         #1 n++;
      end
      n = 32'h0;
      do begin
         @(posedge clk);
         #1 n++;
      end while (burst_start !== 1'b1 && n < 32'd3000);
      chk(n, exp);
      @(posedge clk);
   endtask

   task automatic hold_chk(input int lim, input logic [31:0] lo, input logic [31:0] hi);
      #1;
      for (int i = 0; i < lim && detect_output !== 1'b0; i++) begin
         @(posedge clk);
         #1;
      end
      @(posedge clk);
      #1 chk_rng(high_len, lo, hi);
      @(posedge clk);
   endtask

   // ============================================================
   // Tests
   initial begin
      @(posedge clk);
      restart(8'h60, 8'h02);
      wr(2'h0, 8'ha5);
      rd(2'h0, 8'h60);
      #1 chk(transfer_fast, 1);
      chk(detect_threshold, 2'h2);
      chk(sample_fast, 0);
      @(posedge clk);
      gap(20);
      det(50);
      hold_chk(100, 50, 50);
      det(1);
      hold_chk(100, 4, 5);
      $display("Test active mode done");

      restart(8'hd1, 8'h04);
      rd(2'h1, 8'h04);
      #1 chk(sample_fast, 1);
      chk(detect_threshold, 2'h1);
      chk(transfer_fast, 0);
      @(posedge clk);
      gap(170);
      det(10);
      repeat (20) @(posedge clk);
      #1 chk(detect_output, 1);
      @(posedge clk);
      det(10);
      repeat (5) @(posedge clk);
      #1 chk(detect_output, 0);
      @(posedge clk);
      $display("Test toggle mode done");

      restart(8'h32, 8'h00);
      rd(2'h0, 8'h32);
      gap(100);
      detect_in <= 1'b1;
      gap(20);
      repeat (3400) @(posedge clk);
      #1 chk(detect_output, 1);
      @(posedge clk);
      detect_in <= 1'b0;
      repeat (3) @(posedge clk);
      #1 chk(detect_output, 0);
      repeat (200) @(posedge clk);
      gap(100);
      det(5);
      hold_chk(3100, 3000, 3002);
      $display("Test short latch done");

      restart(8'h83, 8'h00);
      rd(2'h0, 8'h83);
      gap(340);
      det(5);
      repeat (100) @(posedge clk);
      det(5);
      hold_chk(31000, 30105, 30116);
      $display("Test long latch done");
      print_verdict;
   end
endmodule
